// ===== design/fhqg_defines.svh
// Purpose: timing counts, command codes and bus addresses for the flash host sequencer
// Assumes: 20 MHz controller clock
// Notes:   command codes and unlock addresses are plain defaults; adjust for the part in use
`ifndef FHQG_DEFINES_SVH
`define FHQG_DEFINES_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define FHQG_CLK_NS        50
`define FHQG_T_WP_NS       35
`define FHQG_T_ACC_NS      90
`define FHQG_CYC_UP(t)     ((((t) + `FHQG_CLK_NS - 1) / `FHQG_CLK_NS) < 1 ? 1 : \
                            (((t) + `FHQG_CLK_NS - 1) / `FHQG_CLK_NS))
`define FHQG_WP_CYC        `FHQG_CYC_UP(`FHQG_T_WP_NS)
`define FHQG_SYNC_CYC      2
`define FHQG_RD_CYC        (`FHQG_CYC_UP(`FHQG_T_ACC_NS) + `FHQG_SYNC_CYC)

// ----------------------------------------------------------------------
// command cycle addresses and data
// ----------------------------------------------------------------------
`define FHQG_UNLK1_WORD    22'h000555
`define FHQG_UNLK2_WORD    22'h0002AA
`define FHQG_UNLK1_BYTE    22'h000AAA
`define FHQG_UNLK2_BYTE    22'h000555
`define FHQG_QRY_WORD      22'h000055
`define FHQG_QRY_BYTE      22'h0000AA
`define FHQG_D_UNLK1       16'h00AA
`define FHQG_D_UNLK2       16'h0055
`define FHQG_D_QUERY       16'h0098
`define FHQG_D_RESET       16'h00F0
`define FHQG_D_PROGRAM     16'h00A0
`define FHQG_D_AUTOSEL     16'h0090
`define FHQG_D_SSR_ENTER   16'h0088
`define FHQG_D_SSR_EXIT    16'h0000

`endif

// ===== design/fhqg_host.sv
// Purpose: host sequencer driving an asynchronous parallel flash through its pins
// Assumes: one request at a time; flash data pins arrive unsynchronised
// Notes:   outputs are all registered; no accelerate pin, programming always uses full unlock
`timescale 1ns/1ps
`include "fhqg_defines.svh"

module fhqg_host (
  // clock and reset
  input  wire logic                  MCLK_I,
  input  wire logic                  NRST_I,
  // request and response
  input  wire logic                  REQ_VALID_I,
  input  wire fhqg_pkg::fhqg_req_t   REQ_I,
  input  wire logic                  BYTE_MODE_I,
  output logic                       REQ_READY_O,
  output logic                       RESP_VALID_O,
  output logic                       RESP_ERR_O,
  output logic [15:0]                RESP_DATA_O,
  // status
  output logic                       SSR_ACTIVE_O,
  output logic                       QUERY_ACTIVE_O,
  // flash pins
  output logic                       FL_CE_N_O,
  output logic                       FL_WE_N_O,
  output logic                       FL_OE_N_O,
  output logic [21:0]                FL_ADDR_O,
  output logic [15:0]                FL_DQ_O,
  output logic                       FL_DQ_OE_O,
  input  wire logic [15:0]           FL_DQ_I
);

  localparam logic [2:0] WP_LAST = 3'(`FHQG_WP_CYC - 1);
  localparam logic [2:0] RD_LAST = 3'(`FHQG_RD_CYC - 1);

  fhqg_pkg::fhqg_state_t state_r, state_nxt;
  fhqg_pkg::fhqg_mode_t  mode_r, mode_nxt, mode_done_w;
  fhqg_pkg::fhqg_req_t   req_r, req_nxt;
  fhqg_pkg::fhqg_bus_t   step_w;
  logic [1:0]            idx_r, idx_nxt;
  logic [2:0]            cnt_r, cnt_nxt;
  logic                  ssr_r, ssr_nxt, ssr_done_w;
  logic                  ready_r, ready_nxt;
  logic                  resp_v_r, resp_v_nxt;
  logic                  err_r, err_nxt;
  logic [15:0]           data_r, data_nxt;
  logic                  ce_r, ce_nxt, we_r, we_nxt, oe_r, oe_nxt;
  logic [21:0]           addr_r, addr_nxt;
  logic [15:0]           dq_r, dq_nxt;
  logic                  dq_oe_r, dq_oe_nxt;
  logic [15:0]           dq_meta_r, dq_sync_r;
  logic                  in_query_w, refuse_w, finish_w, query_r, query_nxt;
  logic [21:0]           rd_addr_w;

  // ----------------------------------------------------------------------
  // bus cycle table
  // ----------------------------------------------------------------------
  function automatic fhqg_pkg::fhqg_bus_t seq_step(input fhqg_pkg::fhqg_op_t op, input logic [1:0] idx,
                                                   input logic bm, input logic [21:0] rda,
                                                   input logic [21:0] wa, input logic [15:0] wd);
    fhqg_pkg::fhqg_bus_t b;
    logic [15:0]         cmd;
    b   = '{addr: 22'h000000, data: 16'h0000, rd: 1'b0, last: 1'b0};
    cmd = `FHQG_D_AUTOSEL;
    case (op)
      fhqg_pkg::FHQG_OP_WRITE:   cmd = `FHQG_D_PROGRAM;
      fhqg_pkg::FHQG_OP_SSR_IN:  cmd = `FHQG_D_SSR_ENTER;
      default:                   cmd = `FHQG_D_AUTOSEL;
    endcase
    case (op)
      fhqg_pkg::FHQG_OP_READ:  b = '{addr: rda, data: 16'h0000, rd: 1'b1, last: 1'b1};
      fhqg_pkg::FHQG_OP_QUERY: begin
        b = '{addr: bm ? `FHQG_QRY_BYTE : `FHQG_QRY_WORD, data: `FHQG_D_QUERY, rd: 1'b0, last: 1'b1};
      end
      fhqg_pkg::FHQG_OP_RESET: b = '{addr: 22'h000000, data: `FHQG_D_RESET, rd: 1'b0, last: 1'b1};
      default: begin
        // unlock pair, command, then data cycle where the op has one
        case (idx)
          2'h0: b.addr = bm ? `FHQG_UNLK1_BYTE : `FHQG_UNLK1_WORD;
          2'h1: b.addr = bm ? `FHQG_UNLK2_BYTE : `FHQG_UNLK2_WORD;
          2'h2: b.addr = bm ? `FHQG_UNLK1_BYTE : `FHQG_UNLK1_WORD;
          default: b.addr = (op == fhqg_pkg::FHQG_OP_WRITE) ? wa : 22'h000000;
        endcase
        case (idx)
          2'h0: b.data = `FHQG_D_UNLK1;
          2'h1: b.data = `FHQG_D_UNLK2;
          2'h2: b.data = cmd;
          default: b.data = (op == fhqg_pkg::FHQG_OP_WRITE) ? wd : `FHQG_D_SSR_EXIT;
        endcase
        b.last = (op == fhqg_pkg::FHQG_OP_WRITE || op == fhqg_pkg::FHQG_OP_SSR_OUT) ? (idx == 2'h3) :
                 (idx == 2'h2);
      end
    endcase
    return b;
  endfunction : seq_step

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  assign in_query_w = (mode_r == fhqg_pkg::FHQG_M_QUERY) || (mode_r == fhqg_pkg::FHQG_M_QUERY_AS);
  assign query_nxt  = (mode_nxt == fhqg_pkg::FHQG_M_QUERY) || (mode_nxt == fhqg_pkg::FHQG_M_QUERY_AS);
  // query reads take the table index; upper bits forced low, doubled in byte mode
  assign rd_addr_w  = !in_query_w ? req_r.addr :
                      BYTE_MODE_I ? {14'h0000, req_r.addr[6:0], 1'b0} :
                                    {15'h0000, req_r.addr[6:0]};
  assign step_w     = seq_step(req_r.op, idx_r, BYTE_MODE_I, rd_addr_w, req_r.addr, req_r.data);
  // main-array access while the secured region is mapped is refused
  assign refuse_w   = ((REQ_I.op == fhqg_pkg::FHQG_OP_READ || REQ_I.op == fhqg_pkg::FHQG_OP_WRITE) &&
                       !REQ_I.secure && ssr_r) ||
                      (REQ_I.op == fhqg_pkg::FHQG_OP_QUERY && in_query_w) ||
                      (REQ_I.op == fhqg_pkg::FHQG_OP_WRITE && mode_r != fhqg_pkg::FHQG_M_ARRAY);
  assign finish_w   = (state_r == fhqg_pkg::FHQG_S_REC) && step_w.last;
  assign mode_done_w = (req_r.op == fhqg_pkg::FHQG_OP_QUERY) ?
                         ((mode_r == fhqg_pkg::FHQG_M_AUTOSEL) ? fhqg_pkg::FHQG_M_QUERY_AS :
                                                                 fhqg_pkg::FHQG_M_QUERY) :
                       (req_r.op == fhqg_pkg::FHQG_OP_RESET) ?
                         ((mode_r == fhqg_pkg::FHQG_M_QUERY_AS) ? fhqg_pkg::FHQG_M_AUTOSEL :
                                                                  fhqg_pkg::FHQG_M_ARRAY) :
                       (req_r.op == fhqg_pkg::FHQG_OP_AUTOSEL) ? fhqg_pkg::FHQG_M_AUTOSEL : mode_r;
  assign ssr_done_w = (req_r.op == fhqg_pkg::FHQG_OP_SSR_IN)  ? 1'b1 :
                      (req_r.op == fhqg_pkg::FHQG_OP_SSR_OUT) ? 1'b0 : ssr_r;

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt  = state_r;
    mode_nxt   = mode_r;
    req_nxt    = req_r;
    idx_nxt    = idx_r;
    cnt_nxt    = cnt_r;
    ssr_nxt    = ssr_r;
    ready_nxt  = 1'b0;
    resp_v_nxt = 1'b0;
    err_nxt    = 1'b0;
    data_nxt   = data_r;
    ce_nxt     = 1'b1;
    we_nxt     = 1'b1;
    oe_nxt     = 1'b1;
    addr_nxt   = addr_r;
    dq_nxt     = dq_r;
    dq_oe_nxt  = 1'b0;
    case (state_r)
      fhqg_pkg::FHQG_S_IDLE: begin
        ready_nxt = 1'b1;
        if (REQ_VALID_I && ready_r) begin
          if (refuse_w) begin
            resp_v_nxt = 1'b1;
            err_nxt    = 1'b1;
          end else begin
            req_nxt   = REQ_I;
            idx_nxt   = 2'h0;
            ready_nxt = 1'b0;
            state_nxt = fhqg_pkg::FHQG_S_ADDR;
          end
        end
      end
      fhqg_pkg::FHQG_S_ADDR: begin
        ce_nxt    = 1'b0;
        addr_nxt  = step_w.addr;
        dq_nxt    = step_w.data;
        dq_oe_nxt = !step_w.rd;
        cnt_nxt   = 3'h0;
        state_nxt = step_w.rd ? fhqg_pkg::FHQG_S_RD : fhqg_pkg::FHQG_S_WE;
      end
      fhqg_pkg::FHQG_S_WE: begin
        // output enable stays high for the whole strobe
        ce_nxt    = 1'b0;
        we_nxt    = 1'b0;
        dq_oe_nxt = 1'b1;
        cnt_nxt   = cnt_r + 3'h1;
        if (cnt_r == WP_LAST) state_nxt = fhqg_pkg::FHQG_S_REC;
      end
      fhqg_pkg::FHQG_S_RD: begin
        ce_nxt  = 1'b0;
        oe_nxt  = 1'b0;
        cnt_nxt = cnt_r + 3'h1;
        if (cnt_r == RD_LAST) begin
          data_nxt  = dq_sync_r;
          state_nxt = fhqg_pkg::FHQG_S_REC;
        end
      end
      fhqg_pkg::FHQG_S_REC: begin
        // data held one cycle past the write enable rise
        dq_oe_nxt = !step_w.rd;
        if (step_w.last) begin
          resp_v_nxt = 1'b1;
          mode_nxt   = mode_done_w;
          ssr_nxt    = ssr_done_w;
          state_nxt  = fhqg_pkg::FHQG_S_IDLE;
        end else begin
          idx_nxt   = idx_r + 2'h1;
          state_nxt = fhqg_pkg::FHQG_S_ADDR;
        end
      end
      default: state_nxt = fhqg_pkg::FHQG_S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  // write enable idles high from reset so no command can land at power-up
  // flash data is asynchronous: two flops ahead of the read capture
  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_r <= fhqg_pkg::FHQG_S_IDLE;
      mode_r  <= fhqg_pkg::FHQG_M_ARRAY;
      req_r   <= '0;
      {idx_r, cnt_r, ssr_r, query_r, ready_r, resp_v_r, err_r, data_r} <= '0;
      {ce_r, we_r, oe_r} <= 3'h7;
      {addr_r, dq_r, dq_oe_r, dq_meta_r, dq_sync_r} <= '0;
    end else begin
      state_r <= state_nxt;
      mode_r  <= mode_nxt;
      req_r   <= req_nxt;
      {idx_r, cnt_r, ssr_r, query_r, ready_r, resp_v_r, err_r, data_r} <=
        {idx_nxt, cnt_nxt, ssr_nxt, query_nxt, ready_nxt, resp_v_nxt, err_nxt, data_nxt};
      {ce_r, we_r, oe_r} <= {ce_nxt, we_nxt, oe_nxt};
      {addr_r, dq_r, dq_oe_r, dq_meta_r, dq_sync_r} <= {addr_nxt, dq_nxt, dq_oe_nxt, FL_DQ_I, dq_meta_r};
    end
  end

  assign REQ_READY_O    = ready_r;
  assign RESP_VALID_O   = resp_v_r;
  assign RESP_ERR_O     = err_r;
  assign RESP_DATA_O    = data_r;
  assign SSR_ACTIVE_O   = ssr_r;
  assign QUERY_ACTIVE_O = query_r;
  assign FL_CE_N_O      = ce_r;
  assign FL_WE_N_O      = we_r;
  assign FL_OE_N_O      = oe_r;
  assign FL_ADDR_O      = addr_r;
  assign FL_DQ_O        = dq_r;
  assign FL_DQ_OE_O     = dq_oe_r;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!NRST_I);
  sequence s_done(fhqg_pkg::fhqg_op_t o);
    finish_w && req_r.op == o;
  endsequence
  chk_write_gate: assert property (!FL_WE_N_O |-> !FL_CE_N_O && FL_OE_N_O)
    else $error("write strobe without chip enable or with output enable low");
  chk_we_pulse: assert property ($fell(FL_WE_N_O) |=> $rose(FL_WE_N_O) && FL_DQ_OE_O)
    else $error("write strobe width or data hold wrong");
  chk_query_cmd: assert property (!FL_WE_N_O && req_r.op == fhqg_pkg::FHQG_OP_QUERY |->
      FL_DQ_O == `FHQG_D_QUERY && FL_ADDR_O == (BYTE_MODE_I ? `FHQG_QRY_BYTE : `FHQG_QRY_WORD))
    else $error("query entry cycle wrong");
  chk_query_addr: assert property (!FL_OE_N_O && in_query_w && !BYTE_MODE_I |-> FL_ADDR_O[21:7] == 15'h0000)
    else $error("query read with upper address bits set");
  chk_query_exit: assert property (s_done(fhqg_pkg::FHQG_OP_RESET) and (mode_r == fhqg_pkg::FHQG_M_QUERY)
      |=> mode_r == fhqg_pkg::FHQG_M_ARRAY && !QUERY_ACTIVE_O)
    else $error("reset did not leave query for array read");
  chk_query_as: assert property (s_done(fhqg_pkg::FHQG_OP_RESET) and (mode_r == fhqg_pkg::FHQG_M_QUERY_AS)
      |=> mode_r == fhqg_pkg::FHQG_M_AUTOSEL)
    else $error("reset from query did not return to identifier mode");
  chk_ssr_entry: assert property (s_done(fhqg_pkg::FHQG_OP_SSR_IN) |-> idx_r == 2'h2 ##1 SSR_ACTIVE_O)
    else $error("secured entry not three cycles or flag not set");
  chk_ssr_hold: assert property (ssr_r && !finish_w |=> ssr_r)
    else $error("secured mapping dropped without exit");
  chk_array_refused: assert property (REQ_VALID_I && REQ_READY_O && ssr_r && !REQ_I.secure &&
      REQ_I.op == fhqg_pkg::FHQG_OP_READ |=> RESP_VALID_O && RESP_ERR_O && state_r == fhqg_pkg::FHQG_S_IDLE)
    else $error("array access while secured region mapped was not refused");

endmodule : fhqg_host

// ===== design/fhqg_pkg.sv
// Purpose: types shared by the flash host sequencer
// Assumes: 22-bit byte address, 16-bit data bus
// Notes:   state codes are one-hot
package fhqg_pkg;

  typedef enum logic [2:0] {
    FHQG_OP_READ    = 3'h0,
    FHQG_OP_WRITE   = 3'h1,
    FHQG_OP_QUERY   = 3'h2,
    FHQG_OP_RESET   = 3'h3,
    FHQG_OP_SSR_IN  = 3'h4,
    FHQG_OP_SSR_OUT = 3'h5,
    FHQG_OP_AUTOSEL = 3'h6
  } fhqg_op_t;

  typedef enum logic [1:0] {
    FHQG_M_ARRAY    = 2'h0,
    FHQG_M_AUTOSEL  = 2'h1,
    FHQG_M_QUERY    = 2'h2,
    FHQG_M_QUERY_AS = 2'h3
  } fhqg_mode_t;

  typedef enum logic [4:0] {
    FHQG_S_IDLE = 5'h01,
    FHQG_S_ADDR = 5'h02,
    FHQG_S_WE   = 5'h04,
    FHQG_S_RD   = 5'h08,
    FHQG_S_REC  = 5'h10
  } fhqg_state_t;

  typedef struct packed {
    fhqg_op_t    op;
    logic        secure;
    logic [21:0] addr;
    logic [15:0] data;
  } fhqg_req_t;

  typedef struct packed {
    logic [21:0] addr;
    logic [15:0] data;
    logic        rd;
    logic        last;
  } fhqg_bus_t;

endpackage : fhqg_pkg

// ===== verification/fhqg_flash_model.sv
// Purpose: behavioural flash device for the host sequencer bench
// Assumes: a write is latched on falling write enable and committed on its rise
// Notes:   released data pins show the inverse of the last value, so stale data never matches
`timescale 1ns/1ps
module fhqg_flash_model #(
  parameter bit          FACTORY_LOCKED = 1'b1,
  parameter bit          TOP_BOOT       = 1'b0, // 1: top-boot or uniform part, region at the array top
  parameter logic [15:0] ESN_BASE       = 16'h3C00 // arbitrary serial pattern
) (
  // flash pins
  input  wire logic        ce_n_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic [21:0] addr_i,
  input  wire logic [15:0] dq_i,
  output logic      [15:0] dq_o,
  // board conditions
  input  wire logic        byte_mode_i,
  input  wire logic        lockout_i
);
  localparam logic [15:0] QTAB [23] = '{16'h0051, 16'h0052, 16'h0059, 16'h0002, 16'h0000, 16'h0040,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0027, 16'h0036, 16'h0000, 16'h0000,
    16'h0004, 16'h0000, 16'h000A, 16'h0000, 16'h0005, 16'h0000, 16'h0004, 16'h0000};
  logic [15:0] mem [logic [21:0]];
  logic [15:0] electronic_serial_number [128];
  logic [1:0]  mode; // 0 array, 1 identifier, 2 query, 3 query from identifier
  logic        ssr;
  logic [2:0]  step;
  logic        wok;
  logic [21:0] wa;
  logic [15:0] wd, last_q;
  logic [21:0] u1, u2, qa, qi, sbase;
  assign u1 = byte_mode_i ? 22'h000AAA : 22'h000555;
  assign u2 = byte_mode_i ? 22'h000555 : 22'h0002AA;
  assign qa = byte_mode_i ? 22'h0000AA : 22'h000055;
  assign qi = byte_mode_i ? (addr_i >> 1) : addr_i;
  assign sbase = !TOP_BOOT ? 22'h000000 : byte_mode_i ? 22'h3FFF00 : 22'h1FFF80;
  initial begin
    mode = 2'h0;
    ssr  = 1'h0;
    step = 3'h0;
    wok  = 1'h0;
    dq_o = 16'h0000;
    last_q = 16'hFFFF;
    for (int i = 0; i < 128; i++) electronic_serial_number[i] = (i < 8) ? ESN_BASE + 16'(i) : 16'hFFFF;
  end
  // ----------------------------------------------------------------------
  // command decoding
  // ----------------------------------------------------------------------
  always @(negedge we_n_i) begin
    wok = !ce_n_i && oe_n_i && !lockout_i;
    wa  = addr_i;
    wd  = dq_i;
  end
  always @(posedge lockout_i) begin
    mode = 2'h0;
    step = 3'h0;
  end
  always @(posedge we_n_i) if (wok) begin
    wok = 1'h0;
    // program data first: a data word whose low byte looks like a command is still data
    if (step == 3'h3) begin
      if (!ssr) mem[wa] = wd;
      else if (!FACTORY_LOCKED) electronic_serial_number[7'(wa - sbase)] = wd;
      step = 3'h0;
    end
    else if (wd[7:0] == 8'hF0) begin
      mode = (mode == 2'h3) ? 2'h1 : 2'h0;
      step = 3'h0;
    end
    else if (step == 3'h0 && wa == qa && wd[7:0] == 8'h98 && !mode[1]) mode = mode | 2'h2;
    else if (step == 3'h4) begin
      ssr  = 1'h0;
      step = 3'h0;
    end
    else if (step == 3'h0 && wa == u1 && wd[7:0] == 8'hAA) step = 3'h1;
    else if (step == 3'h1 && wa == u2 && wd[7:0] == 8'h55) step = 3'h2;
    else if (step == 3'h2 && wd[7:0] == 8'hA0) step = 3'h3; // only the full unlock path programs
    else if (step == 3'h2 && wd[7:0] == 8'h88) begin
      ssr  = 1'h1;
      step = 3'h0;
    end
    else if (step == 3'h2 && wd[7:0] == 8'h90) begin
      if (!ssr) mode = 2'h1;
      step = ssr ? 3'h4 : 3'h0;
    end
    else step = 3'h0;
  end
  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  always @(ce_n_i, oe_n_i, addr_i, mode, ssr, sbase, qi) begin
    if (!ce_n_i && !oe_n_i) begin
      if (mode[1]) dq_o = (qi >= 22'h10 && qi <= 22'h26) ? QTAB[qi[5:0] - 6'h10] : 16'hDEAD;
      else if (mode == 2'h1) dq_o = (addr_i[7:0] == 8'h03) ? {8'h00, FACTORY_LOCKED, 7'h00} : 16'h0000;
      else if (ssr && (addr_i - sbase) < 22'h80) dq_o = electronic_serial_number[7'(addr_i - sbase)];
      else dq_o = mem.exists(addr_i) ? mem[addr_i] : (addr_i[15:0] ^ 16'hA5A5);
      last_q = dq_o;
    end
    else dq_o = ~last_q;
  end
endmodule : fhqg_flash_model

// ===== verification/tb_top.sv
// Purpose: self-checking bench for the flash host sequencer
// Assumes: behavioural flash model on the pins
// Notes:   expectations queue up in request order and are matched against each response
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic err; logic chk; logic [15:0] data;} fhqg_exp_t;
  localparam logic [15:0] ELECTRONIC_SERIAL_NUMBER = 16'h3C00; // arbitrary serial pattern
  localparam logic [15:0] QTAB [23] = '{16'h0051, 16'h0052, 16'h0059, 16'h0002, 16'h0000, 16'h0040,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0027, 16'h0036, 16'h0000, 16'h0000,
    16'h0004, 16'h0000, 16'h000A, 16'h0000, 16'h0005, 16'h0000, 16'h0004, 16'h0000};
  logic MCLK_I = 1'h0, NRST_I = 1'h0, REQ_VALID_I = 1'h0, BYTE_MODE_I = 1'h0, lockout = 1'h0;
  fhqg_pkg::fhqg_req_t REQ_I = '0;
  logic        REQ_READY_O, RESP_VALID_O, RESP_ERR_O, SSR_ACTIVE_O, QUERY_ACTIVE_O;
  logic        ce_n, we_n, oe_n, dq_oe;
  logic [15:0] RESP_DATA_O, host_dq, dev_dq, dq_bus;
  logic [21:0] fl_addr;
  int          error_cnt = 0, n_compared = 0, seed = 23948;
  fhqg_exp_t   exp_q[$];
  fhqg_exp_t   e;
  assign dq_bus = dq_oe ? host_dq : dev_dq;
  always #25 MCLK_I = ~MCLK_I;
  fhqg_host i_fhqg_host (.MCLK_I(MCLK_I), .NRST_I(NRST_I), .REQ_VALID_I(REQ_VALID_I), .REQ_I(REQ_I),
    .BYTE_MODE_I(BYTE_MODE_I), .REQ_READY_O(REQ_READY_O), .RESP_VALID_O(RESP_VALID_O),
    .RESP_ERR_O(RESP_ERR_O), .RESP_DATA_O(RESP_DATA_O), .SSR_ACTIVE_O(SSR_ACTIVE_O),
    .QUERY_ACTIVE_O(QUERY_ACTIVE_O), .FL_CE_N_O(ce_n), .FL_WE_N_O(we_n), .FL_OE_N_O(oe_n),
    .FL_ADDR_O(fl_addr), .FL_DQ_O(host_dq), .FL_DQ_OE_O(dq_oe), .FL_DQ_I(dq_bus));
  fhqg_flash_model #(.FACTORY_LOCKED(1'b1), .ESN_BASE(ELECTRONIC_SERIAL_NUMBER)) i_fhqg_flash_model (.ce_n_i(ce_n),
    .we_n_i(we_n), .oe_n_i(oe_n), .addr_i(fl_addr), .dq_i(host_dq), .dq_o(dev_dq),
    .byte_mode_i(BYTE_MODE_I), .lockout_i(lockout));
  // ----------------------------------------------------------------------
  // compare, request and closing tasks
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  // holds the request until the edge that samples ready high, then waits for its response
  task automatic req(input fhqg_pkg::fhqg_op_t op, input logic s, input logic [21:0] a,
                     input logic [15:0] d, input logic err, input logic chk, input logic [15:0] ed);
    int n;
    exp_q.push_back('{err, chk, ed});
    @(posedge MCLK_I);
    REQ_VALID_I <= 1'h1;
    REQ_I       <= '{op, s, a, d};
    n = 0;
    do @(posedge MCLK_I); while (REQ_READY_O !== 1'h1 && n++ < 100);
    REQ_VALID_I <= 1'h0;
    if (n > 100) begin
      $display("[ERR] req_ready expected 1 seen %b", REQ_READY_O);
      error_cnt++;
      end_of_test();
    end
    n = 0;
    while (exp_q.size() != 0 && n++ < 200) @(posedge MCLK_I);
    if (n > 200) begin
      $display("[ERR] resp_valid expected 1 seen %b", RESP_VALID_O);
      error_cnt++;
      end_of_test();
    end
  endtask : req
  task automatic rd(input logic s, input logic [21:0] a, input logic err, input logic [15:0] ed);
    req(fhqg_pkg::FHQG_OP_READ, s, a, 16'h0000, err, ~err, ed);
  endtask : rd
  task automatic cmd(input fhqg_pkg::fhqg_op_t op, input logic err);
    req(op, 1'h0, 22'h000000, 16'h0000, err, 1'h0, 16'h0000);
  endtask : cmd
  always @(posedge MCLK_I) if (RESP_VALID_O === 1'h1) begin
    if (exp_q.size() == 0) check("spare response", 16'h0000, 16'h0001);
    else begin
      e = exp_q.pop_front();
      check("resp_err", {15'h0000, e.err}, {15'h0000, RESP_ERR_O});
      if (e.chk) check("resp_data", e.data, RESP_DATA_O);
    end
  end
  initial begin
    repeat (20000) @(posedge MCLK_I);
    $display("[ERR] watchdog expected response seen none");
    error_cnt++;
    end_of_test();
  end
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  initial begin : main
    logic [21:0] a;
    logic [15:0] d;
    repeat (8) @(posedge MCLK_I);
    NRST_I <= 1'h1;
    repeat (2) @(posedge MCLK_I);
    for (int i = 0; i < 6; i++) begin
      a = 22'($random(seed)) | 22'h000100;
      d = 16'($random(seed));
      rd(1'h0, a, 1'h0, a[15:0] ^ 16'hA5A5);
      req(fhqg_pkg::FHQG_OP_WRITE, 1'h0, a, d, 1'h0, 1'h0, 16'h0000);
      rd(1'h0, a, 1'h0, d);
    end
    cmd(fhqg_pkg::FHQG_OP_QUERY, 1'h0);
    check("query_flag", 16'h0001, {15'h0000, QUERY_ACTIVE_O});
    for (int i = 0; i < 23; i++) rd(1'h0, 22'(16 + i), 1'h0, QTAB[i]);
    cmd(fhqg_pkg::FHQG_OP_QUERY, 1'h1);
    req(fhqg_pkg::FHQG_OP_WRITE, 1'h0, 22'h000080, 16'h1234, 1'h1, 1'h0, 16'h0000);
    cmd(fhqg_pkg::FHQG_OP_RESET, 1'h0);
    check("query_flag", 16'h0000, {15'h0000, QUERY_ACTIVE_O});
    rd(1'h0, 22'h000040, 1'h0, 16'h0040 ^ 16'hA5A5);
    cmd(fhqg_pkg::FHQG_OP_AUTOSEL, 1'h0);
    rd(1'h0, 22'h000003, 1'h0, 16'h0080);
    cmd(fhqg_pkg::FHQG_OP_QUERY, 1'h0);
    rd(1'h0, 22'h000010, 1'h0, 16'h0051);
    cmd(fhqg_pkg::FHQG_OP_RESET, 1'h0);
    rd(1'h0, 22'h000003, 1'h0, 16'h0080);
    cmd(fhqg_pkg::FHQG_OP_RESET, 1'h0);
    cmd(fhqg_pkg::FHQG_OP_SSR_IN, 1'h0);
    check("ssr_flag", 16'h0001, {15'h0000, SSR_ACTIVE_O});
    rd(1'h0, 22'h000040, 1'h1, 16'h0000);
    for (int i = 0; i < 8; i++) rd(1'h1, 22'(i), 1'h0, ELECTRONIC_SERIAL_NUMBER + 16'(i));
    req(fhqg_pkg::FHQG_OP_WRITE, 1'h1, 22'h000001, 16'h0000, 1'h0, 1'h0, 16'h0000);
    rd(1'h1, 22'h000001, 1'h0, ELECTRONIC_SERIAL_NUMBER + 16'h0001);
    cmd(fhqg_pkg::FHQG_OP_SSR_OUT, 1'h0);
    check("ssr_flag", 16'h0000, {15'h0000, SSR_ACTIVE_O});
    rd(1'h0, 22'h000002, 1'h0, 16'h0002 ^ 16'hA5A5);
    lockout <= 1'h1;
    req(fhqg_pkg::FHQG_OP_WRITE, 1'h0, 22'h000050, 16'h5A5A, 1'h0, 1'h0, 16'h0000);
    lockout <= 1'h0;
    rd(1'h0, 22'h000050, 1'h0, 16'h0050 ^ 16'hA5A5);
    BYTE_MODE_I <= 1'h1;
    cmd(fhqg_pkg::FHQG_OP_QUERY, 1'h0);
    for (int i = 0; i < 3; i++) rd(1'h0, 22'(16 + i), 1'h0, QTAB[i]);
    cmd(fhqg_pkg::FHQG_OP_RESET, 1'h0);
    end_of_test();
  end
endmodule : tb_top
